/* File: verif/host_mcu_model.sv */
// host microcontroller model: measures how long it is held in reset
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic host_reset_out_low,
  output var  int   low_len
);
  int cnt;

  // a low line holds the host in reset; length latched on release
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      cnt     <= 0;
      low_len <= 0;
    end
    else if (host_reset_out_low !== 1'b1)
      cnt <= cnt + 1;
    else if (cnt != 0)
    begin
      low_len <= cnt;
      cnt     <= 0;
    end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// testbench of the fail-safe mode controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  // shortened timing so the tested mode paths (all but Sleep) fit in a short run
  localparam logic [31:0] SHORT   = 32'd20;
  localparam logic [31:0] LONG    = 32'd40;
  localparam logic [31:0] WD_INIT = 32'd100;
  localparam logic [31:0] WD_PER  = 32'd60;
  localparam logic [31:0] INT_LIM = 32'd30;
  localparam logic [31:0] FS_DLY  = 32'd10;
  logic           ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic           host_reset_out_low, host_irq_low, enable_out, err;
  logic           inhibit_fallback_output, transceiver_active;
  logic           controller_supply_regulator;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, rdv;
  fsc_pkg::pins_t pin_in;
  int             low_len, n_mismatch, samples_checked, cyc;

  failsafe_mode_controller #(
    .RST_SHORT_CYC(SHORT), .RST_LONG_CYC(LONG), .WD_INIT_CYC(WD_INIT),
    .WD_PERIOD_CYC(WD_PER), .INT_LIMIT_CYC(INT_LIM),
    .RESTART_DLY_CYC(FS_DLY)
  ) DUT (
    .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pin_in, .host_reset_out_low, .host_irq_low,
    .enable_out, .inhibit_fallback_output, .transceiver_active,
    .controller_supply_regulator
  );

  host_mcu_model host (.ref_clk, .rst_b, .host_reset_out_low, .low_len);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // generous ceiling: the whole sequence needs about 800 cycles
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic st(input logic [31:0] e);
    apb(1'b0, fsc_pkg::OFS_STAT, 32'h0);
    chk("stat", e, rdv & 32'h010f_03ff);
  endtask

  task automatic wait_rst(input logic v);
    for (int i = 0; i < 400 && host_reset_out_low !== v; i++)
      @(posedge ref_clk);
    chk("reset_level", {31'h0, v}, {31'h0, host_reset_out_low});
  endtask

  // host model latches the exact low length on release
  task automatic len(input logic [31:0] e);
    chk("stretch", e, 32'(low_len));
  endtask

  task automatic wake(input logic b);
    pin_in.bus_wake   <= b;
    pin_in.local_wake <= !b;
    repeat (8) @(posedge ref_clk);
    pin_in.bus_wake   <= 1'b0;
    pin_in.local_wake <= 1'b0;
    @(posedge ref_clk);
  endtask

  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin_in = fsc_pkg::PINS_RST;
    n_mismatch = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    st(32'h0101_0001);
    wait_rst(1'b1);
    st(32'h0100_0002);
    len(SHORT);
    $display("test power_up done");
    apb(1'b1, fsc_pkg::OFS_WDOG, 32'h0);
    st(32'h0100_0010);
    chk("outs", 32'h6, 32'({enable_out, inhibit_fallback_output,
        transceiver_active}));
    apb(1'b1, fsc_pkg::OFS_CTRL, 32'h4);
    @(posedge ref_clk);
    chk("trx", 32'h1, 32'(transceiver_active));
    apb(1'b1, fsc_pkg::OFS_CTRL, 32'h9);
    wait_rst(1'b0);
    chk("off", 32'h0, 32'({enable_out, transceiver_active}));
    wait_rst(1'b1);
    st(32'h0106_0002);
    len(LONG);
    $display("test long_select done");
    apb(1'b1, fsc_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, fsc_pkg::OFS_WDOG, 32'h0);
    repeat (40) @(posedge ref_clk);
    apb(1'b1, fsc_pkg::OFS_WDOG, 32'h0);
    chk("served", 32'h1, 32'(host_reset_out_low));
    apb(1'b1, fsc_pkg::OFS_WDOG, 32'h0);
    wait_rst(1'b0);
    chk("en_wd", 32'h0, 32'(enable_out));
    wait_rst(1'b1);
    st(32'h0103_0002);
    len(SHORT);
    $display("test watchdog done");
    apb(1'b1, fsc_pkg::OFS_WDOG, 32'h0);
    wake(1'b1);
    chk("irq_low", 32'h0, 32'(host_irq_low));
    apb(1'b0, fsc_pkg::OFS_IRQ, 32'h0);
    chk("irq_reg", 32'h1, rdv & 32'h1);
    chk("irq_clr", 32'h1, 32'(host_irq_low));
    repeat (25) @(posedge ref_clk);
    apb(1'b1, fsc_pkg::OFS_WDOG, 32'h0);
    wake(1'b1);
    wait_rst(1'b0);
    wait_rst(1'b1);
    st(32'h0104_0002);
    $display("test interrupt done");
    wait_rst(1'b0);
    wait_rst(1'b1);
    st(32'h0102_0008);
    len(LONG);
    apb(1'b1, fsc_pkg::OFS_WDOG, 32'h0);
    st(32'h0100_0010);
    $display("test restart done");
    apb(1'b1, fsc_pkg::OFS_CTRL, 32'h10);
    st(32'h0100_0040);
    chk("stby_outs", 32'h3, 32'({enable_out, inhibit_fallback_output,
        controller_supply_regulator}));
    wake(1'b1);
    wait_rst(1'b0);
    wait_rst(1'b1);
    st(32'h0105_0002);
    len(SHORT);
    apb(1'b1, fsc_pkg::OFS_CTRL, 32'h2);
    apb(1'b1, fsc_pkg::OFS_WDOG, 32'h0);
    st(32'h0100_0020);
    $display("test standby_flash done");
    pin_in.severe_fault <= 1'b1;
    repeat (8) @(posedge ref_clk);
    st(32'h0100_0100);
    chk("fs_outs", 32'h0, 32'({enable_out, inhibit_fallback_output,
        controller_supply_regulator}));
    pin_in.severe_fault <= 1'b0;
    pin_in.osc_ok <= 1'b0;
    wake(1'b1);
    st(32'h0000_0100);
    pin_in.osc_ok <= 1'b1;
    repeat (8) @(posedge ref_clk);
    wake(1'b0);
    wait_rst(1'b1);
    chk("reg_on", 32'h1, 32'(controller_supply_regulator));
    st(32'h0107_0002);
    wait_rst(1'b0);
    wait_rst(1'b1);
    wait_rst(1'b0);
    st(32'h0102_0100);
    $display("test failsafe done");
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    chk("rdata", 32'h0, rdv);
    $display("test unmapped done");
    report_and_stop();
  end
endmodule
`default_nettype wire

/* File: verilog/failsafe_mode_controller.sv */
// fail-safe mode controller: mode state machine with APB registers
`timescale 1ns/1ps
`default_nettype none
module failsafe_mode_controller #(
  parameter logic [31:0] RST_SHORT_CYC = 32'(fsc_pkg::RST_SHORT_CYC),
  parameter logic [31:0] RST_LONG_CYC = 32'(fsc_pkg::RST_LONG_CYC),
  parameter logic [31:0] WD_INIT_CYC = 32'(fsc_pkg::WD_INIT_CYC),
  parameter logic [31:0] WD_PERIOD_CYC = 32'(fsc_pkg::WD_PERIOD_CYC),
  parameter logic [31:0] INT_LIMIT_CYC = 32'(fsc_pkg::INT_LIMIT_CYC),
  parameter logic [31:0] RESTART_DLY_CYC =
    32'(fsc_pkg::RESTART_DLY_CYC)
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire fsc_pkg::pins_t pin_in,
  output logic               host_reset_out_low,
  output logic               host_irq_low,
  output logic               enable_out,
  output logic               inhibit_fallback_output,
  output logic               transceiver_active,
  output logic               controller_supply_regulator
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  fsc_pkg::state_t state_reg;
  fsc_pkg::state_t state_next;
  fsc_pkg::pins_t  s1_reg;
  fsc_pkg::pins_t  s2_reg;
  fsc_pkg::pins_t  s3_reg;
  fsc_pkg::pins_t  pin_reg;
  fsc_pkg::pins_t  pin_next;
  fsc_pkg::ctrl_t  ctrl_reg;
  fsc_pkg::ctrl_t  ctrl_next;
  logic [31:0]     timer_reg;
  logic [31:0]     timer_next;
  logic [31:0]     int_reg;
  logic [31:0]     int_next;
  logic [3:0]      rsrc_reg;
  logic [3:0]      rsrc_next;
  logic            long_reg;
  logic            long_next;
  logic            irq_reg;
  logic            irq_next;
  logic            wake_prev_reg;
  logic [31:0]     rdata_mux;

  // pin filter: a change counts once stages two and three agree
  assign pin_next = (s2_reg & s3_reg) | (pin_reg & (s2_reg | s3_reg));

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_reg <= fsc_pkg::PINS_RST;
      s2_reg <= fsc_pkg::PINS_RST;
      s3_reg <= fsc_pkg::PINS_RST;
      pin_reg <= fsc_pkg::PINS_RST;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
    end
  end

  // APB decode
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire a_ctrl = hit(paddr, fsc_pkg::OFS_CTRL);
  wire a_wdog = hit(paddr, fsc_pkg::OFS_WDOG);
  wire a_irq = hit(paddr, fsc_pkg::OFS_IRQ);
  wire a_stat = hit(paddr, fsc_pkg::OFS_STAT);
  wire mapped = a_ctrl | a_wdog | a_irq | a_stat;
  wire ctrl_wr = wr & a_ctrl;
  wire wd_wr = wr & a_wdog;
  wire irq_rd = rd & a_irq;
  wire stat_rd = rd & a_stat;
  wire soft_rst = ctrl_wr & pwdata[fsc_pkg::CB_SRST];
  wire [1:0] mode_req = ctrl_wr ?
    pwdata[fsc_pkg::CB_MODE +: 2] : 2'h0;

  // state decode
  wire st_start_rst = state_reg == fsc_pkg::S_START_RST;
  wire st_start_wait = state_reg == fsc_pkg::S_START_WAIT;
  wire st_restart_rst = state_reg == fsc_pkg::S_RESTART_RST;
  wire st_restart_wait = state_reg == fsc_pkg::S_RESTART_WAIT;
  wire st_normal = state_reg == fsc_pkg::S_NORMAL;
  wire st_flash = state_reg == fsc_pkg::S_FLASH;
  wire st_low = state_reg == fsc_pkg::S_STANDBY ||
                state_reg == fsc_pkg::S_SLEEP;
  wire st_fs_delay = state_reg == fsc_pkg::S_FS_DELAY;
  wire st_run = st_normal | st_flash;

  // events
  wire fault_now = pin_reg.severe_fault | ~pin_reg.osc_ok;
  wire wake_now = pin_reg.bus_wake | pin_reg.local_wake;
  wire [31:0] stretch_len = (long_reg | ctrl_reg.rls) ?
    RST_LONG_CYC : RST_SHORT_CYC;
  wire [31:0] timer_lim =
    (st_start_rst | st_restart_rst) ? stretch_len :
    (st_start_wait | st_restart_wait) ? WD_INIT_CYC :
    st_fs_delay ? RESTART_DLY_CYC : WD_PERIOD_CYC;
  wire timer_done = timer_reg >= timer_lim - 32'h1;
  // window mode only in Normal; too early a service is a failure
  wire wd_early = st_normal & wd_wr &
    (timer_reg < (WD_PERIOD_CYC >> 1));
  wire wd_late = timer_done & ~wd_wr;
  wire wd_fail = st_run & (wd_early | wd_late);
  wire int_late = st_normal & irq_reg &
    (int_reg >= INT_LIMIT_CYC - 32'h1);
  wire sys_reset = wd_fail | int_late | (st_run & soft_rst) |
    (st_low & wake_now);
  wire wd_serve = st_run & wd_wr & ~wd_early;

  // reset source code for the transition being taken
  wire [3:0] rs_code =
    st_fs_delay ? fsc_pkg::RS_FS_EXIT :
    st_start_wait ? fsc_pkg::RS_WD_INIT :
    st_low ? fsc_pkg::RS_WAKE :
    int_late ? fsc_pkg::RS_INT_TMO :
    wd_fail ? fsc_pkg::RS_WD_FAIL : fsc_pkg::RS_SOFT;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      fsc_pkg::S_START_RST:
        if (timer_done)
          state_next = fsc_pkg::S_START_WAIT;
      fsc_pkg::S_START_WAIT:
        if (wd_wr)
          state_next = ctrl_reg.flash_sel ?
            fsc_pkg::S_FLASH : fsc_pkg::S_NORMAL;
        else if (timer_done)
          state_next = fsc_pkg::S_RESTART_RST;
      fsc_pkg::S_RESTART_RST:
        if (pin_reg.supply_fail)
          state_next = fsc_pkg::S_FAILSAFE;
        else if (timer_done)
          state_next = fsc_pkg::S_RESTART_WAIT;
      fsc_pkg::S_RESTART_WAIT:
        if (wd_wr)
          state_next = fsc_pkg::S_NORMAL;
        else if (timer_done | pin_reg.supply_fail)
          state_next = fsc_pkg::S_FAILSAFE;
      fsc_pkg::S_NORMAL, fsc_pkg::S_FLASH:
        if (sys_reset)
          state_next = fsc_pkg::S_START_RST;
        else if (st_normal && mode_req == fsc_pkg::MODE_STANDBY)
          state_next = fsc_pkg::S_STANDBY;
        else if (st_normal && mode_req == fsc_pkg::MODE_SLEEP)
          state_next = fsc_pkg::S_SLEEP;
      fsc_pkg::S_STANDBY, fsc_pkg::S_SLEEP:
        if (wake_now)
          state_next = fsc_pkg::S_START_RST;
      fsc_pkg::S_FAILSAFE:
        if (wake_now & pin_reg.osc_ok)
          state_next = fsc_pkg::S_FS_DELAY;
      fsc_pkg::S_FS_DELAY:
        if (timer_done)
          state_next = fsc_pkg::S_START_RST;
      default:
        state_next = fsc_pkg::S_START_RST;
    endcase
    if (fault_now)
      state_next = fsc_pkg::S_FAILSAFE;
  end

  wire changing = state_next != state_reg;
  wire to_rst = changing &&
    (state_next == fsc_pkg::S_START_RST ||
     state_next == fsc_pkg::S_RESTART_RST);

  // new cause wins over a read in the same cycle
  assign rsrc_next = to_rst ? rs_code :
    stat_rd ? fsc_pkg::RS_NONE : rsrc_reg;
  assign long_next = (state_next == fsc_pkg::S_RESTART_RST) |
    (st_fs_delay & changing) |
    (long_reg & state_next != fsc_pkg::S_NORMAL);
  assign timer_next = (changing | wd_serve) ? 32'h0 :
    timer_reg + 32'h1;
  assign int_next = (st_normal & irq_reg) ? int_reg + 32'h1 : 32'h0;
  // interrupt set wins over the clearing read
  assign irq_next = (st_normal & wake_now & ~wake_prev_reg) |
    (irq_reg & ~irq_rd & st_normal);

  // transceiver bit forgotten outside Normal, so entry never enables it
  assign ctrl_next.rls = ctrl_wr ? pwdata[fsc_pkg::CB_RLS] :
    ctrl_reg.rls;
  assign ctrl_next.flash_sel = ctrl_wr ? pwdata[fsc_pkg::CB_FLASH] :
    ctrl_reg.flash_sel;
  assign ctrl_next.trx = (state_next == fsc_pkg::S_NORMAL) &
    (ctrl_wr ? pwdata[fsc_pkg::CB_TRX] : ctrl_reg.trx);

  wire nx_rst_low = state_next == fsc_pkg::S_START_RST ||
    state_next == fsc_pkg::S_RESTART_RST ||
    state_next == fsc_pkg::S_SLEEP ||
    state_next == fsc_pkg::S_FAILSAFE ||
    state_next == fsc_pkg::S_FS_DELAY;
  wire nx_power_off = state_next == fsc_pkg::S_SLEEP ||
    state_next == fsc_pkg::S_FAILSAFE ||
    state_next == fsc_pkg::S_FS_DELAY;

  assign rdata_mux =
    a_ctrl ? {29'h0, ctrl_reg} :
    a_irq ? {31'h0, irq_reg} :
    a_stat ? ({22'h0, state_reg} |
      (32'(rsrc_reg) << fsc_pkg::SB_RSRC) |
      (32'(pin_reg.osc_ok) << fsc_pkg::SB_OSC)) : 32'h0;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= fsc_pkg::S_START_RST;
      ctrl_reg <= fsc_pkg::CTRL_RST;
      timer_reg <= 32'h0;
      int_reg <= 32'h0;
      rsrc_reg <= fsc_pkg::RS_POWER_ON;
      long_reg <= 1'b0;
      irq_reg <= 1'b0;
      wake_prev_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      timer_reg <= timer_next;
      int_reg <= int_next;
      rsrc_reg <= rsrc_next;
      long_reg <= long_next;
      irq_reg <= irq_next;
      wake_prev_reg <= wake_now;
    end
  end

  // mode outputs registered from next state so they track state_reg from the first clock edge after reset
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      host_reset_out_low <= 1'b0;
      host_irq_low <= 1'b1;
      enable_out <= 1'b0;
      inhibit_fallback_output <= 1'b0;
      transceiver_active <= 1'b0;
      controller_supply_regulator <= 1'b1;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      host_reset_out_low <= ~nx_rst_low;
      host_irq_low <= ~irq_next;
      enable_out <= state_next == fsc_pkg::S_NORMAL;
      inhibit_fallback_output <= ~nx_power_off;
      transceiver_active <= ctrl_next.trx;
      controller_supply_regulator <= ~nx_power_off;
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & ~pwrite) ? rdata_mux : 32'h0;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_por_startup: assert property (
    $rose(rst_b) |-> state_reg == fsc_pkg::S_START_RST)
    else $error("power-up did not start in Start-up");

  a_reset_to_start: assert property (
    sys_reset && !fault_now |=> state_reg == fsc_pkg::S_START_RST)
    else $error("system reset did not reach Start-up");

  a_rsrc_capture: assert property (
    to_rst |=> rsrc_reg == $past(rs_code) && rsrc_reg != 4'h0)
    else $error("reset cause not captured");

  a_wake_start: assert property (
    st_low && wake_now && !fault_now
    |=> state_reg == fsc_pkg::S_START_RST ##1 !host_reset_out_low)
    else $error("wake did not start reset sequence");

  a_reset_held: assert property (
    st_start_rst && !timer_done && !fault_now
    |=> st_start_rst && !host_reset_out_low)
    else $error("reset released before stretch elapsed");

  a_stretch_sel: assert property (
    st_start_rst && ctrl_reg.rls |-> timer_lim == RST_LONG_CYC)
    else $error("stretch ignores select bit");

  a_init_fail: assert property (
    st_start_wait && timer_done && !wd_wr && !fault_now
    |=> state_reg == fsc_pkg::S_RESTART_RST)
    else $error("failed init did not enter Restart");

  a_restart_long: assert property (
    st_restart_rst |-> long_reg && timer_lim == RST_LONG_CYC)
    else $error("Restart without long stretch");

  a_fault_fs: assert property (
    fault_now |=> state_reg == fsc_pkg::S_FAILSAFE ##1
      !controller_supply_regulator)
    else $error("fault did not enter Fail-safe");

  a_fs_hold: assert property (
    state_reg == fsc_pkg::S_FAILSAFE && !(wake_now && pin_reg.osc_ok)
    |=> state_reg == fsc_pkg::S_FAILSAFE)
    else $error("Fail-safe left without wake");

  a_int_tmo: assert property (
    int_late && !fault_now |=> rsrc_reg == fsc_pkg::RS_INT_TMO)
    else $error("interrupt timeout not reset");

  a_trx_sw: assert property (
    $rose(st_normal) |-> !transceiver_active)
    else $error("transceiver active on Normal entry");

  a_en_low: assert property (
    sys_reset |=> !enable_out [*2])
    else $error("enable not low on reset");

endmodule
`default_nettype wire

/* File: verilog/fsc_pkg.sv */
// package: constants and types of the fail-safe mode controller
package fsc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_SHORT_US = 1000;
  localparam int RST_LONG_US = 20000;
  localparam int WD_INIT_US = 256000;
  localparam int WD_PERIOD_US = 64000;
  localparam int INT_LIMIT_US = 20000;
  localparam int RESTART_DLY_US = 1000;
  localparam int RST_SHORT_CYC = RST_SHORT_US * 1000 / CLK_PERIOD_NS;
  localparam int RST_LONG_CYC = RST_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam int WD_INIT_CYC = WD_INIT_US * 1000 / CLK_PERIOD_NS;
  localparam int WD_PERIOD_CYC = WD_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int INT_LIMIT_CYC = INT_LIMIT_US * 1000 / CLK_PERIOD_NS;
  localparam int RESTART_DLY_CYC = RESTART_DLY_US * 1000 / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WDOG = 8'h04;
  localparam logic [7:0] OFS_IRQ = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;

  localparam int CB_RLS = 0;
  localparam int CB_FLASH = 1;
  localparam int CB_TRX = 2;
  localparam int CB_SRST = 3;
  localparam int CB_MODE = 4;
  localparam int SB_RSRC = 16;
  localparam int SB_OSC = 24;
  localparam logic [1:0] MODE_STANDBY = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;

  localparam logic [3:0] RS_NONE = 4'h0;
  localparam logic [3:0] RS_POWER_ON = 4'h1;
  localparam logic [3:0] RS_WD_INIT = 4'h2;
  localparam logic [3:0] RS_WD_FAIL = 4'h3;
  localparam logic [3:0] RS_INT_TMO = 4'h4;
  localparam logic [3:0] RS_WAKE = 4'h5;
  localparam logic [3:0] RS_SOFT = 4'h6;
  localparam logic [3:0] RS_FS_EXIT = 4'h7;

  typedef enum logic [9:0] {
    S_START_RST    = 10'h001,
    S_START_WAIT   = 10'h002,
    S_RESTART_RST  = 10'h004,
    S_RESTART_WAIT = 10'h008,
    S_NORMAL       = 10'h010,
    S_FLASH        = 10'h020,
    S_STANDBY      = 10'h040,
    S_SLEEP        = 10'h080,
    S_FAILSAFE     = 10'h100,
    S_FS_DELAY     = 10'h200
  } state_t;

  typedef struct packed {
    logic bus_wake;
    logic local_wake;
    logic osc_ok;
    logic severe_fault;
    logic supply_fail;
  } pins_t;

  typedef struct packed {
    logic trx;
    logic flash_sel;
    logic rls;
  } ctrl_t;

  localparam pins_t PINS_RST = 5'h04;
  localparam ctrl_t CTRL_RST = 3'h0;
endpackage
